// ==== common/tcm_pkg.sv ====
// Purpose: Shared constants and types for the three-channel temperature limit monitor.
// Assumes: Byte-wide register port with 4-bit offsets; converter results arrive as strobes.
// Notes: Channel 0 and 1 are remote diodes, channel 2 is the on-die diode.
// Contract
// - Readout is signed byte, one degree per step
// - Per-channel readout at 0Bh, read-only, resets zero
// - Per-channel high limit at 0Ch, compared each reading
// - Per-channel low limit at 0Dh, compared each reading
// - Per-channel overtemp limit at 0Eh, compared each reading
// - Event status 00h: remote1, remote2, local bit pairs
// - Offset 02h enables each event onto SMI
// - Offset 04h enables each event onto IRQ
// - Bank field selects channel; values above 2 reserved
// - Limit flags bits 3-1 cleared by writing one
// - End-of-conversion flag set on load, write-one clears
// - Low flag set when readout below low limit
package tcm_pkg;

  localparam int unsigned TCM_NUM_CH = 3;

  // Register offsets
  localparam logic [3:0] TCM_OFS_EVT_STATUS = 4'h0;
  localparam logic [3:0] TCM_OFS_EVT_SMI_EN = 4'h2;
  localparam logic [3:0] TCM_OFS_EVT_IRQ_EN = 4'h4;
  localparam logic [3:0] TCM_OFS_MON_CONFIG = 4'h8;
  localparam logic [3:0] TCM_OFS_BANK_SEL = 4'h9;
  localparam logic [3:0] TCM_OFS_CH_CFG_STS = 4'hA;
  localparam logic [3:0] TCM_OFS_CH_READOUT = 4'hB;
  localparam logic [3:0] TCM_OFS_CH_HIGH = 4'hC;
  localparam logic [3:0] TCM_OFS_CH_LOW = 4'hD;
  localparam logic [3:0] TCM_OFS_CH_OVER = 4'hE;

  // Reset values
  localparam logic [7:0] TCM_RST_READOUT = 8'h00;
  localparam logic [7:0] TCM_RST_HIGH = 8'h7F;
  localparam logic [7:0] TCM_RST_LOW = 8'hC9;
  localparam logic [7:0] TCM_RST_OVER = 8'h7F;
  localparam logic [1:0] TCM_RST_MON_CONFIG = 2'h3;
  localparam logic [3:0] TCM_RST_BANK = 4'h0;

  // Channel configuration and status bit positions
  localparam int unsigned TCM_CFS_EOC = 7;
  localparam int unsigned TCM_CFS_OPEN = 6;
  localparam int unsigned TCM_CFS_OTS_OE = 5;
  localparam int unsigned TCM_CFS_ALERT_OE = 4;
  localparam int unsigned TCM_CFS_OVER = 3;
  localparam int unsigned TCM_CFS_HIGH = 2;
  localparam int unsigned TCM_CFS_LOW = 1;
  localparam int unsigned TCM_CFS_EN = 0;

  // Monitor configuration bit positions
  localparam int unsigned TCM_CFG_STANDBY = 0;
  localparam int unsigned TCM_CFG_EXT_VREF = 1;

  // Event field width (two bits per channel)
  localparam int unsigned TCM_EVT_W = 2 * TCM_NUM_CH;

  // Register port request from the logical-device I/O window
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tcm_reg_req_t;

  // Converter result strobe
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic open_fault;
    logic signed [7:0] temp;
  } tcm_conv_t;

  // Per-channel limits and configuration
  typedef struct packed {
    logic signed [7:0] high;
    logic signed [7:0] low;
    logic signed [7:0] over;
    logic en;
    logic alert_oe;
    logic ots_oe;
  } tcm_ch_cfg_t;

endpackage

// ==== hdl/tcm_chan_regs.sv ====
// Purpose: Writable limit and configuration storage for one temperature channel.
// Assumes: Caller gates i_wr_en with the bank selection for this channel.
// Notes: Status flags live in the top module; only software-owned state is kept here.
module tcm_chan_regs
  import tcm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  output tcm_ch_cfg_t o_cfg
);

  tcm_ch_cfg_t cfg_r;

  // Limits and enables take software writes directly
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      cfg_r.high <= TCM_RST_HIGH;
      cfg_r.low <= TCM_RST_LOW;
      cfg_r.over <= TCM_RST_OVER;
      cfg_r.en <= 1'b0;
      cfg_r.alert_oe <= 1'b0;
      cfg_r.ots_oe <= 1'b0;
    end
    else if (i_wr_en)
    begin
      unique case (i_addr)
        TCM_OFS_CH_HIGH: cfg_r.high <= i_wdata;
        TCM_OFS_CH_LOW: cfg_r.low <= i_wdata;
        TCM_OFS_CH_OVER: cfg_r.over <= i_wdata;
        TCM_OFS_CH_CFG_STS:
        begin
          cfg_r.en <= i_wdata[TCM_CFS_EN];
          cfg_r.alert_oe <= i_wdata[TCM_CFS_ALERT_OE];
          cfg_r.ots_oe <= i_wdata[TCM_CFS_OTS_OE];
        end
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  assign o_cfg = cfg_r;

endmodule

// ==== hdl/tcm_monitor.sv ====
// Purpose: Register file, limit comparison and event routing of the temperature monitor.
// Assumes: Register requests and converter strobes are synchronous to i_core_clk.
// Notes: Read data is registered and valid the cycle after a read strobe.
module tcm_monitor
  import tcm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input tcm_reg_req_t i_reg,
  input tcm_conv_t i_conv,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_smi,
  output logic o_irq,
  output logic o_alert,
  output logic o_overtemp_shutdown_output,
  output logic o_standby,
  output logic o_ext_vref
);

  logic [3:0] bank_r;
  logic [1:0] mon_cfg_r;
  logic [TCM_EVT_W-1:0] evt_status_r;
  logic [TCM_EVT_W-1:0] evt_smi_en_r;
  logic [TCM_EVT_W-1:0] evt_irq_en_r;
  logic [TCM_EVT_W-1:0] evt_set;
  logic [TCM_NUM_CH-1:0] alert_lvl;
  logic [TCM_NUM_CH-1:0] ots_lvl;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic bank_ok;
  logic [7:0] bank_rd;
  logic [1:0] bank_idx;
  tcm_ch_cfg_t ch_cfg [TCM_NUM_CH];
  logic [7:0] ch_readout_r [TCM_NUM_CH];
  logic [7:0] ch_flags_r [TCM_NUM_CH];
  logic [7:0] ch_cfs [TCM_NUM_CH];

  // Reserved bank codes select nothing, so banked accesses there read zero
  assign bank_ok = (bank_r < 4'(TCM_NUM_CH));
  assign bank_idx = bank_r[1:0];

  // Global writable registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      bank_r <= TCM_RST_BANK;
      mon_cfg_r <= TCM_RST_MON_CONFIG;
      evt_smi_en_r <= '0;
      evt_irq_en_r <= '0;
    end
    else if (i_reg.wr)
    begin
      unique case (i_reg.addr)
        TCM_OFS_BANK_SEL: bank_r <= i_reg.wdata[3:0];
        TCM_OFS_MON_CONFIG: mon_cfg_r <= i_reg.wdata[1:0];
        TCM_OFS_EVT_SMI_EN: evt_smi_en_r <= i_reg.wdata[TCM_EVT_W-1:0];
        TCM_OFS_EVT_IRQ_EN: evt_irq_en_r <= i_reg.wdata[TCM_EVT_W-1:0];
        default: bank_r <= bank_r;
      endcase
    end
  end

  assign o_standby = mon_cfg_r[TCM_CFG_STANDBY];
  assign o_ext_vref = mon_cfg_r[TCM_CFG_EXT_VREF];

  // One slice per channel: limits, readout, flags and event sources
  genvar gc;
  generate
    for (gc = 0; gc < TCM_NUM_CH; gc++)
    begin : g_ch
      logic sel_wr;
      logic load;
      logic w1c;
      logic hi_hit;
      logic lo_hit;
      logic ot_hit;

      assign sel_wr = i_reg.wr && bank_ok && (bank_idx == 2'(gc));
      // Standby parks the converter path, so stray strobes are ignored
      assign load = i_conv.valid && (i_conv.chan == 2'(gc)) && !o_standby;
      assign w1c = sel_wr && (i_reg.addr == TCM_OFS_CH_CFG_STS);

      tcm_chan_regs u_regs (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_wr_en(sel_wr),
        .i_addr(i_reg.addr),
        .i_wdata(i_reg.wdata),
        .o_cfg(ch_cfg[gc])
      );

      // Signed compares against the new sample, not the stored one
      assign hi_hit = load && (i_conv.temp > ch_cfg[gc].high);
      assign lo_hit = load && (i_conv.temp < ch_cfg[gc].low);
      assign ot_hit = load && (i_conv.temp > ch_cfg[gc].over);

      // Latest sample per channel
      always_ff @(posedge i_core_clk)
      begin
        if (i_srst)
          ch_readout_r[gc] <= TCM_RST_READOUT;
        else if (load)
          ch_readout_r[gc] <= i_conv.temp;
      end

      // Sticky flags; a hardware set beats a same-cycle write-one clear
      always_ff @(posedge i_core_clk)
      begin
        if (i_srst)
          ch_flags_r[gc] <= '0;
        else
        begin
          ch_flags_r[gc][TCM_CFS_EOC] <= load ||
            (ch_flags_r[gc][TCM_CFS_EOC] && !(w1c && i_reg.wdata[TCM_CFS_EOC]));
          ch_flags_r[gc][TCM_CFS_OPEN] <= (load && i_conv.open_fault) ||
            (ch_flags_r[gc][TCM_CFS_OPEN] && !(w1c && i_reg.wdata[TCM_CFS_OPEN]));
          ch_flags_r[gc][TCM_CFS_OVER] <= ot_hit ||
            (ch_flags_r[gc][TCM_CFS_OVER] && !(w1c && i_reg.wdata[TCM_CFS_OVER]));
          ch_flags_r[gc][TCM_CFS_HIGH] <= hi_hit ||
            (ch_flags_r[gc][TCM_CFS_HIGH] && !(w1c && i_reg.wdata[TCM_CFS_HIGH]));
          ch_flags_r[gc][TCM_CFS_LOW] <= lo_hit ||
            (ch_flags_r[gc][TCM_CFS_LOW] && !(w1c && i_reg.wdata[TCM_CFS_LOW]));
        end
      end

      // Readback view merges software config with hardware flags
      always_comb
      begin
        ch_cfs[gc] = ch_flags_r[gc];
        ch_cfs[gc][TCM_CFS_EN] = ch_cfg[gc].en;
        ch_cfs[gc][TCM_CFS_ALERT_OE] = ch_cfg[gc].alert_oe;
        ch_cfs[gc][TCM_CFS_OTS_OE] = ch_cfg[gc].ots_oe;
      end

      // Event sources are gated by channel and output enables
      assign evt_set[2*gc] = (hi_hit || lo_hit) && ch_cfg[gc].en &&
        ch_cfg[gc].alert_oe;
      assign evt_set[2*gc+1] = ot_hit && ch_cfg[gc].en && ch_cfg[gc].ots_oe;

      // Pin levels follow the sticky flags until software clears them
      assign alert_lvl[gc] = ch_cfg[gc].en && ch_cfg[gc].alert_oe &&
        (ch_flags_r[gc][TCM_CFS_HIGH] || ch_flags_r[gc][TCM_CFS_LOW]);
      assign ots_lvl[gc] = ch_cfg[gc].en && ch_cfg[gc].ots_oe &&
        ch_flags_r[gc][TCM_CFS_OVER];
    end
  endgenerate

  // Event status: sticky, write-one-to-clear, set wins over clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      evt_status_r <= '0;
    else if (i_reg.wr && (i_reg.addr == TCM_OFS_EVT_STATUS))
      evt_status_r <= evt_set | (evt_status_r & ~i_reg.wdata[TCM_EVT_W-1:0]);
    else
      evt_status_r <= evt_set | evt_status_r;
  end

  // Interrupt routing; a status bit reaches a line only when enabled for it
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_smi <= 1'b0;
      o_irq <= 1'b0;
      o_alert <= 1'b0;
      o_overtemp_shutdown_output <= 1'b0;
    end
    else
    begin
      o_smi <= |(evt_status_r & evt_smi_en_r);
      o_irq <= |(evt_status_r & evt_irq_en_r);
      o_alert <= |alert_lvl;
      o_overtemp_shutdown_output <= |ots_lvl;
    end
  end

  // Banked window mux; reserved bank codes read zero
  always_comb
  begin
    bank_rd = '0;
    if (bank_ok)
    begin
      unique case (i_reg.addr)
        TCM_OFS_CH_CFG_STS: bank_rd = ch_cfs[bank_idx];
        TCM_OFS_CH_READOUT: bank_rd = ch_readout_r[bank_idx];
        TCM_OFS_CH_HIGH: bank_rd = ch_cfg[bank_idx].high;
        TCM_OFS_CH_LOW: bank_rd = ch_cfg[bank_idx].low;
        TCM_OFS_CH_OVER: bank_rd = ch_cfg[bank_idx].over;
        default: bank_rd = '0;
      endcase
    end
  end

  // Registered read data; reserved offsets and bits read as zero
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= i_reg.rd;
      if (i_reg.rd)
      begin
        unique case (i_reg.addr)
          TCM_OFS_EVT_STATUS: rdata_r <= 8'(evt_status_r);
          TCM_OFS_EVT_SMI_EN: rdata_r <= 8'(evt_smi_en_r);
          TCM_OFS_EVT_IRQ_EN: rdata_r <= 8'(evt_irq_en_r);
          TCM_OFS_MON_CONFIG: rdata_r <= 8'(mon_cfg_r);
          TCM_OFS_BANK_SEL: rdata_r <= 8'(bank_r);
          default: rdata_r <= bank_rd;
        endcase
      end
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;

endmodule

// ==== tb/tcm_monitor_checker.sv ====
// Purpose: Port-level timing checks of the temperature monitor.
// Assumes: Sees only the top module ports; one clock domain.
// Notes: Bank is shadowed from writes so reserved-bank reads can be judged.
module tcm_monitor_checker
  import tcm_pkg::*;
(
  input logic i_core_clk,
  input logic i_srst,
  input tcm_reg_req_t i_reg,
  input tcm_conv_t i_conv,
  input logic [7:0] o_rdata,
  input logic o_rvalid,
  input logic o_smi,
  input logic o_irq,
  input logic o_alert,
  input logic o_overtemp_shutdown_output,
  input logic o_standby,
  input logic o_ext_vref
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] bank_r;
  // Shadow bank copy; only the low nibble is meaningful
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      bank_r <= TCM_RST_BANK;
    else if (i_reg.wr && i_reg.addr == TCM_OFS_BANK_SEL)
      bank_r <= i_reg.wdata[3:0];
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  AST_RST: assert property ($fell(i_srst) |-> !o_rvalid && !o_smi && !o_irq && !o_alert
    && o_rdata == 8'h00 && o_standby && o_ext_vref) else $error("reset outputs wrong");
  AST_RVALID: assert property (i_reg.rd |=> o_rvalid) else $error("read not answered");
  AST_NO_RVALID: assert property (!i_reg.rd |=> !o_rvalid) else $error("stray answer");
  AST_RSVD: assert property (i_reg.rd && (i_reg.addr inside {1, 3, 5, 6, 7, 15})
    |=> o_rdata == 8'h00) else $error("reserved offset not zero");
  AST_BANK: assert property (i_reg.rd && i_reg.addr >= 4'hA && i_reg.addr <= 4'hE
    && bank_r > 4'h2 |=> o_rdata == 8'h00) else $error("reserved bank not zero");
  AST_SMI: assert property ($rose(o_smi) |-> $past(i_conv.valid, 2) || $past(i_reg.wr, 2))
    else $error("smi rose without cause");
  AST_IRQ: assert property ($rose(o_irq) |-> $past(i_conv.valid, 2) || $past(i_reg.wr, 2))
    else $error("irq rose without cause");
  AST_ALERT: assert property ($rose(o_alert) |-> ##[0:0] $past(i_conv.valid, 2)
    || $past(i_reg.wr, 2)) else $error("alert rose without cause");
  AST_OTS: assert property ($rose(o_overtemp_shutdown_output)
    |-> $past(i_conv.valid, 2) || $past(i_reg.wr, 2)) else $error("shutdown without cause");
  COV_SMI: cover property ($rose(o_smi));
  COV_IRQ: cover property ($rose(o_irq));
  COV_OTS: cover property ($rose(o_overtemp_shutdown_output));
endmodule
bind tcm_monitor tcm_monitor_checker u_tcm_monitor_checker (.i_core_clk(i_core_clk),
  .i_srst(i_srst), .i_reg(i_reg), .i_conv(i_conv), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_smi(o_smi), .o_irq(o_irq), .o_alert(o_alert), .o_standby(o_standby),
  .o_overtemp_shutdown_output(o_overtemp_shutdown_output), .o_ext_vref(o_ext_vref));

// ==== tb/tcm_conv_model.sv ====
// Purpose: Behavioural analog converter handing results to the monitor.
// Assumes: One result per call, launched just after a rising edge.
// Notes: Idle lines toggle each cycle so a stale result cannot pass.
module tcm_conv_model
  import tcm_pkg::*;
(
  input wire logic i_core_clk,
  output tcm_conv_t o_conv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_conv = '0;
  end
  // Between results the data lines show the inverse of the last value
  always @(posedge i_core_clk)
  begin
    if (!o_conv.valid)
      o_conv <= {1'b0, ~o_conv[10:0]};
  end
  // One-cycle strobe carrying a signed degree count
  task automatic send(input logic [1:0] ch, input logic op, input logic [7:0] t);
    @(posedge i_core_clk);
    #1;
    o_conv = {1'b1, ch, op, t};
    @(posedge i_core_clk);
    #1;
    o_conv.valid = 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the temperature limit monitor.
// Assumes: Strobes last one cycle; read data answers one cycle later.
// Notes: Reads push their expected byte; a watcher retires them in order.
module tb_top
  import tcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  tcm_reg_req_t req = '0;
  tcm_conv_t conv;
  logic [7:0] o_rdata;
  logic o_rvalid, o_smi, o_irq, o_alert, o_ots, o_standby, o_ext_vref;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hE36C;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  tcm_monitor u_tcm_monitor (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_reg(req),
    .i_conv(conv), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_smi(o_smi), .o_irq(o_irq),
    .o_alert(o_alert), .o_overtemp_shutdown_output(o_ots), .o_standby(o_standby),
    .o_ext_vref(o_ext_vref));
  tcm_conv_model u_tcm_conv_model (.i_core_clk(i_core_clk), .o_conv(conv));
  // 50 MHz clock
  initial
  begin
    forever #10 i_core_clk = ~i_core_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      fails++;
      $display("ERROR t=%0t got %h want %h", $time, seen, expv);
    end
  endtask
  // Register access; a read only notes its expectation, the watcher compares
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    req = {w, !w, a, d};
    if (!w)
      exp_q.push_back(d);
    @(posedge i_core_clk);
    #1;
    req[13:12] = 2'b00;
  endtask
  task automatic print_verdict();
    if (exp_q.size() != 0)
      fails++;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watcher; an answer with nothing noted compares against unknown and fails
  always @(negedge i_core_clk)
  begin
    if (o_rvalid === 1'b1)
      check(o_rdata, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
  end
  // Hang guard, far above the roughly 500 cycles the sequence needs
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    #1;
    i_srst = 1'b0;
    acc(0, 4'h0, 8'h00);
    acc(0, 4'h2, 8'h00);
    acc(0, 4'h4, 8'h00);
    acc(0, 4'h8, 8'h03);
    acc(0, 4'h9, 8'h00);
    acc(1, 4'h1, 8'hFF);
    acc(0, 4'h1, 8'h00);
    // Reset values in every bank; the reserved bank reads zero
    for (int b = 0; b < 4; b++)
    begin
      logic [7:0] k;
      k = (b < 3) ? 8'hFF : 8'h00;
      acc(1, 4'h9, 8'hF0 | 8'(b));
      acc(0, 4'h9, 8'(b));
      acc(0, 4'hB, 8'h00);
      acc(0, 4'hC, 8'h7F & k);
      acc(0, 4'hD, 8'hC9 & k);
      acc(0, 4'hE, 8'h7F & k);
    end
    // Standby drops samples and the readout cannot be written
    acc(1, 4'h9, 8'h00);
    u_tcm_conv_model.send(2'd0, 1'b0, 8'h40);
    acc(1, 4'hB, 8'h55);
    acc(0, 4'hB, 8'h00);
    acc(1, 4'h8, 8'h00);
    check({6'h00, o_ext_vref, o_standby}, 8'h00);
    // Channel code 3 names no channel, so bank 0 must stay untouched
    u_tcm_conv_model.send(2'd3, 1'b1, 8'h7F);
    acc(0, 4'hB, 8'h00);
    acc(0, 4'hA, 8'h00);
    acc(1, 4'h2, 8'h3F);
    // Random limits, temperatures, output enables and IRQ enable masks
    for (int i = 0; i < 12; i++)
    begin
      logic [1:0] ch;
      logic [7:0] t, hi, lo, ov, cf, ev, m, msk;
      logic h, l, o, e;
      ch = 2'(i % 3);
      {t, ov, lo, hi} = xs();
      m = 8'(xs());
      // Channel enable is random too, so its gating of events is exercised
      e = 1'(xs());
      cf = {2'b00, m[1:0], 3'h0, e};
      msk = {2'b00, m[7:2]};
      acc(1, 4'h9, {6'h00, ch});
      acc(1, 4'hC, hi);
      acc(1, 4'hD, lo);
      acc(1, 4'hE, ov);
      acc(1, 4'hA, cf);
      acc(1, 4'h4, msk);
      u_tcm_conv_model.send(ch, m[6], t);
      h = $signed(t) > $signed(hi);
      l = $signed(t) < $signed(lo);
      o = $signed(t) > $signed(ov);
      ev = 8'({cf[5] & o, cf[4] & (h | l)} & {2{e}}) << (2 * ch);
      acc(0, 4'hB, t);
      acc(0, 4'hC, hi);
      acc(0, 4'hD, lo);
      acc(0, 4'hE, ov);
      acc(0, 4'hA, {1'b1, m[6], cf[5:4], o, h, l, e});
      acc(0, 4'h0, ev);
      check({6'h00, o_smi, o_irq}, {6'h00, ev != 0, (ev & msk) != 0});
      check({6'h00, o_alert, o_ots}, {6'h00, e & cf[4] & (h | l), e & cf[5] & o});
      acc(1, 4'hA, {2'b11, cf[5:4], 3'h7, e});
      acc(0, 4'hA, cf);
      acc(1, 4'h0, 8'h3F);
      acc(0, 4'h0, 8'h00);
    end
    repeat (2) @(posedge i_core_clk);
    print_verdict();
  end
endmodule
